// File: stcd_decoder.sv
// secure tone command decoder: characters, sequence check, timers, commands
`timescale 1ns/10ps
module stcd_decoder #(
    parameter int NINTH_DELAY_LEN = stcd_pkg::NINTH_DELAY_CYC,
    parameter int HOLD_OFF_LEN = stcd_pkg::HOLD_OFF_CYC,
    parameter int WINDOW_LEN = stcd_pkg::WINDOW_CYC,
    parameter int INTERVAL_LEN = stcd_pkg::INTERVAL_CYC,
    parameter int RECOVERY_LEN = stcd_pkg::RECOVERY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // tone detector pulses, asynchronous
    input wire logic [stcd_pkg::NUM_TONES-1:0] tone_det,
    // mission code plug: character number for each address position
    input wire logic [stcd_pkg::NUM_POS-1:0][stcd_pkg::CHAR_W-1:0] code_plug,
    // command outputs and status
    output logic [stcd_pkg::NUM_CMDS-1:0] cmd_out,
    output logic function_window,
    output logic reject_latch,
    output logic false_char,
    output logic message_reset
);
    import stcd_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [NUM_TONES-1:0] tone_m;
        logic [NUM_TONES-1:0] tone_s;
        logic [NUM_POS-1:0][CHAR_W-1:0] plug_m;
        logic [NUM_POS-1:0][CHAR_W-1:0] plug_s;
        logic [NUM_CHARS-1:0] char_prev;
        logic [NUM_FLAGS-1:0] position_flag;
        logic [NUM_FLAGS-1:0][AGE_W-1:0] age;
        logic first_seen;
        logic reject_latch;
        logic false_q;
        logic reset_q;
        logic win_q;
        logic [NUM_CMDS-1:0] first_function_stage;
        logic [NUM_CMDS-1:0] second_function_stage;
    } stcd_state_type;

    localparam logic [AGE_W-1:0] SETTLE_AGE = AGE_W'(SETTLE_CYC);

    stcd_state_type st_ff;
    stcd_state_type nxt_st;

    logic [NUM_CHARS-1:0] char_lvl;
    logic [NUM_CHARS-1:0] char_pulse;
    logic [NUM_CHARS-1:0] used;
    logic [NUM_POS-1:0] addr_pulse;
    logic [NUM_FLAGS-1:0] flag_eff;
    logic [NUM_FLAGS-1:0] prev_eff;
    logic [NUM_POS-1:0] flag_ext;
    logic [NUM_POS-1:0] oos;
    logic unused_pulse;
    logic false_now;
    logic ninth_ok;
    logic verify;
    logic int_start;
    logic clr_busy;
    logic ninth_done;
    logic hold_done;
    logic win_busy;
    logic int_busy;
    logic int_done;
    logic recov_busy;

    // ****************************************************************
    // character forming and sequence check
    // ****************************************************************

    // pairwise AND of synchronised tones, then rising edges
    always_comb
    begin
        char_lvl = '0;
        for (int lo = 0; lo < NUM_TONES; lo++)
        begin
            for (int hi = lo + 1; hi < NUM_TONES; hi++)
            begin
                char_lvl[char_index(lo, hi)] = st_ff.tone_s[lo] & st_ff.tone_s[hi];
            end
        end
        // edges seen during a clear are dropped, not deferred
        char_pulse = char_lvl & ~st_ff.char_prev & {NUM_CHARS{~clr_busy}};
    end

    // code plug unscrambling; out-of-range plug entries map to nothing
    always_comb
    begin
        used = '0;
        addr_pulse = '0;
        for (int p = 0; p < NUM_POS; p++)
        begin
            if (32'(st_ff.plug_s[p]) < NUM_CHARS)
            begin
                used[st_ff.plug_s[p]] = 1'b1;
                addr_pulse[p] = char_pulse[st_ff.plug_s[p]];
            end
        end
        unused_pulse = |(char_pulse & ~used);
    end

    // settled flags and out-of-sequence detection
    always_comb
    begin
        oos = '0;
        for (int p = 0; p < NUM_FLAGS; p++)
        begin
            flag_eff[p] = st_ff.position_flag[p] && (st_ff.age[p] == SETTLE_AGE);
        end
        // position one has no predecessor; position nine has no flag of its own
        prev_eff = {flag_eff[NUM_FLAGS-2:0], 1'b1};
        flag_ext = {1'b0, st_ff.position_flag};
        for (int p = 1; p < NUM_POS; p++)
        begin
            // a repeat of an accepted character is harmless
            oos[p] = addr_pulse[p] && !flag_eff[p-1] && !flag_ext[p];
        end
        false_now = unused_pulse | (|oos);
        ninth_ok = addr_pulse[NUM_POS-1] && flag_eff[NUM_FLAGS-1] && !false_now;
        verify = ninth_done && int_busy && !st_ff.reject_latch && !false_now;
        int_start = (addr_pulse[0] || (false_now && !st_ff.first_seen)) && !recov_busy;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        // two-flop synchronisers for pins and the plug straps
        nxt_st.tone_m = tone_det;
        nxt_st.tone_s = st_ff.tone_m;
        nxt_st.plug_m = code_plug;
        nxt_st.plug_s = st_ff.plug_m;
        nxt_st.char_prev = char_lvl;
        nxt_st.false_q = false_now;
        nxt_st.reset_q = int_done;
        nxt_st.win_q = win_busy;
        // sequence register
        if (int_done || false_now)
        begin
            nxt_st.position_flag = '0;
            nxt_st.age = '0;
        end
        else
        begin
            for (int p = 0; p < NUM_FLAGS; p++)
            begin
                if (addr_pulse[p] && (prev_eff[p] || st_ff.position_flag[p]))
                    nxt_st.position_flag[p] = 1'b1;
                if (st_ff.position_flag[p] && st_ff.age[p] != SETTLE_AGE)
                    nxt_st.age[p] = st_ff.age[p] + 1'b1;
            end
        end
        // first character seen, cleared with the message
        if (int_done)
            nxt_st.first_seen = 1'b0;
        if (addr_pulse[0] && !false_now)
            nxt_st.first_seen = 1'b1;
        // reject latch: a false event in the expiry cycle still wins
        nxt_st.reject_latch = false_now || (st_ff.reject_latch && !int_done);
        // function stages live only while the window is powered
        if (!win_busy)
        begin
            nxt_st.first_function_stage = '0;
            nxt_st.second_function_stage = '0;
        end
        else
        begin
            for (int c = 0; c < NUM_CMDS; c++)
            begin
                if (char_pulse[CMD_FIRST[c]])
                    nxt_st.first_function_stage[c] = 1'b1;
                if (char_pulse[CMD_SECOND[c]] && st_ff.first_function_stage[c])
                    nxt_st.second_function_stage[c] = 1'b1;
            end
        end
    end

    // state register; power-up leaves every flag clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // ****************************************************************
    // timers
    // ****************************************************************

    // register clear pulse after a false character
    stcd_timer #(.LEN(CLEAR_CYC)) u_clear (
        .clk(clk),
        .reset_n(reset_n),
        .start(false_now),
        .abort(1'b0),
        .busy(clr_busy),
        .done()
    );

    // ninth character delay
    stcd_timer #(.LEN(NINTH_DELAY_LEN)) u_ninth (
        .clk(clk),
        .reset_n(reset_n),
        .start(ninth_ok),
        .abort(int_done),
        .busy(),
        .done(ninth_done)
    );

    // hold-off keeps a ninth character from arming a function stage
    stcd_timer #(.LEN(HOLD_OFF_LEN)) u_hold (
        .clk(clk),
        .reset_n(reset_n),
        .start(verify),
        .abort(int_done),
        .busy(),
        .done(hold_done)
    );

    // function window
    stcd_timer #(.LEN(WINDOW_LEN)) u_window (
        .clk(clk),
        .reset_n(reset_n),
        .start(hold_done),
        .abort(int_done),
        .busy(win_busy),
        .done()
    );

    // message interval
    stcd_timer #(.LEN(INTERVAL_LEN)) u_interval (
        .clk(clk),
        .reset_n(reset_n),
        .start(int_start),
        .abort(1'b0),
        .busy(int_busy),
        .done(int_done)
    );

    // recovery after expiry before the interval may restart
    stcd_timer #(.LEN(RECOVERY_LEN)) u_recovery (
        .clk(clk),
        .reset_n(reset_n),
        .start(int_done),
        .abort(1'b0),
        .busy(recov_busy),
        .done()
    );

    // ****************************************************************
    // outputs, all from flops
    // ****************************************************************
    assign cmd_out = st_ff.second_function_stage;
    assign function_window = st_ff.win_q;
    assign reject_latch = st_ff.reject_latch;
    assign false_char = st_ff.false_q;
    assign message_reset = st_ff.reset_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    pair_forms_char_a: assert property (char_pulse[char_index(0, 1)] |-> st_ff.tone_s[0] && st_ff.tone_s[1])
        else $error("character formed without both tones");
    unused_is_false_a: assert property (unused_pulse |-> false_now ##1 false_char)
        else $error("unused character gave no false pulse");
    first_sets_flag_a: assert property (addr_pulse[0] && !false_now && !int_done |=> st_ff.position_flag[0])
        else $error("first address character did not set its flag");
    oos_gives_false_a: assert property (addr_pulse[2] && !st_ff.position_flag[1] |=> false_char)
        else $error("out of sequence character not flagged");
    repeat_no_false_a: assert property (char_pulse == (1 << st_ff.plug_s[1]) && st_ff.position_flag[1]
        && st_ff.plug_s[1] != st_ff.plug_s[0] && 32'(st_ff.plug_s[1]) < NUM_CHARS |-> !false_now)
        else $error("repeat of accepted character gave false pulse");
    settle_delay_a: assert property ($rose(st_ff.position_flag[0]) |-> !flag_eff[0] [*8])
        else $error("position flag took effect without delay");
    false_sets_reject_a: assert property (false_now |=> reject_latch && st_ff.position_flag == '0)
        else $error("false pulse did not set reject and clear flags");
    reject_holds_a: assert property (reject_latch && !int_done |=> reject_latch)
        else $error("reject latch dropped before expiry");
    expiry_resets_a: assert property (int_done && !false_now |=> !reject_latch && st_ff.position_flag == '0
        && !st_ff.first_seen && message_reset)
        else $error("interval expiry did not reset decoder");
    recovery_blocks_a: assert property (recov_busy |=> !$rose(int_busy))
        else $error("interval restarted during recovery");
    false_starts_timer_a: assert property (false_now && !st_ff.first_seen && !int_busy && !recov_busy |=> int_busy)
        else $error("false pulse did not start the interval timer");
    verify_gated_a: assert property (ninth_done && st_ff.reject_latch |-> !verify)
        else $error("verify passed with reject latch set");
    hold_then_open_a: assert property (hold_done |=> win_busy ##1 function_window)
        else $error("window did not open after hold-off");
    no_cmd_outside_a: assert property (cmd_out != '0 |-> function_window)
        else $error("command output outside the window");
    second_needs_first_a: assert property ($rose(cmd_out[0]) |-> $past(st_ff.first_function_stage[0]))
        else $error("second stage set without first stage");
    close_clears_a: assert property ($fell(win_busy) |=> cmd_out == '0 && st_ff.first_function_stage == '0)
        else $error("stages not cleared at window close");
    clear_suppress_a: assert property (clr_busy |-> char_pulse == '0)
        else $error("character decoded during register clear");

endmodule : stcd_decoder

// File: stcd_pkg.sv
// constants shared by the secure tone command decoder
package stcd_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_TONES = 7;
    localparam int NUM_CHARS = 21;
    localparam int NUM_POS = 9;
    localparam int NUM_FLAGS = 8;
    localparam int NUM_CMDS = 5;
    localparam int CHAR_W = 5;
    localparam int AGE_W = 5;
    localparam int TMR_W = 24;

    // ****************************************************************
    // timing, as printed or chosen, and cycle counts at 20 MHz
    // ****************************************************************
    localparam int CLK_KHZ = 20000;
    localparam int HOLD_OFF_US = 8500;
    localparam int NINTH_DELAY_US = 8500;
    localparam int WINDOW_US = 25000;
    localparam int INTERVAL_US = 120000;
    localparam int RECOVERY_US = 5000;
    localparam int SETTLE_NS = 1000;
    localparam int CLEAR_NS = 1000;
    // scale the clock first: the interval product would overflow a 32-bit int
    localparam int HOLD_OFF_CYC = HOLD_OFF_US * (CLK_KHZ / 1000);
    localparam int NINTH_DELAY_CYC = NINTH_DELAY_US * (CLK_KHZ / 1000);
    localparam int WINDOW_CYC = WINDOW_US * (CLK_KHZ / 1000);
    localparam int INTERVAL_CYC = INTERVAL_US * (CLK_KHZ / 1000);
    localparam int RECOVERY_CYC = RECOVERY_US * (CLK_KHZ / 1000);
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_KHZ + 999999) / 1000000;
    localparam int CLEAR_CYC = (CLEAR_NS * CLK_KHZ + 999999) / 1000000;

    // ****************************************************************
    // character numbering: tones lo < hi, zero based
    // ****************************************************************
    function automatic int char_index(input int lo, input int hi);
        char_index = lo * (13 - lo) / 2 + hi - lo - 1;
    endfunction : char_index

    // command order: destruct, arm-cutoff, spare one, spare two, safe
    localparam int CMD_FIRST [NUM_CMDS] = '{char_index(0, 1), char_index(1, 2),
        char_index(3, 4), char_index(2, 3), char_index(4, 5)};
    localparam int CMD_SECOND [NUM_CMDS] = '{char_index(0, 2), char_index(1, 3),
        char_index(3, 5), char_index(2, 4), char_index(4, 6)};

endpackage : stcd_pkg

// File: stcd_timer.sv
// one-shot interval timer standing in for a monostable
`timescale 1ns/10ps
module stcd_timer #(
    parameter int LEN = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic busy,
    output logic done
);
    import stcd_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic busy;
        logic done;
    } stcd_tmr_state_type;

    localparam logic [TMR_W-1:0] LEN_M1 = TMR_W'(LEN - 1);

    stcd_tmr_state_type st_ff;
    stcd_tmr_state_type nxt_st;

    // busy for LEN cycles, then a one-cycle done; no retrigger while busy
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (abort)
        begin
            nxt_st.busy = 1'b0;
            nxt_st.cnt = '0;
        end
        else if (st_ff.busy)
        begin
            if (st_ff.cnt == '0)
            begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
        else if (start)
        begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = LEN_M1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign busy = st_ff.busy;
    assign done = st_ff.done;

endmodule : stcd_timer

// File: stcd_tone_src.sv
// tone receiver front end model: detector pulses for the decoder
`timescale 1ns/10ps
module stcd_tone_src (
    // clock
    input wire logic clk,
    // detector pulses, one line a tone
    output logic [stcd_pkg::NUM_TONES-1:0] tone_det
);
    import stcd_pkg::*;

    // ****************************************************************
    // detector outputs
    // ****************************************************************
    // a silent filter leaves its detector low, so released lines read 0
    initial tone_det = '0;

    // tones for hold cycles, then silence; period counted from the start
    task automatic send(input logic [NUM_TONES-1:0] mask, input int hold, input int gap);
        @(posedge clk);
        #2;
        tone_det = mask;
        repeat (hold) @(posedge clk);
        #2;
        tone_det = '0;
        repeat (gap - 1) @(posedge clk);
        // hand back off the edge so callers never sample in the launch step
        #2;
    endtask : send
endmodule : stcd_tone_src

// File: tb_secure_tone_command_decoder.sv
// self-checking testbench for the secure tone command decoder
`timescale 1ns/10ps
module tb_secure_tone_command_decoder;
    import stcd_pkg::*;
    // short counts keep the run brief
    localparam int T_NINTH = 40;
    localparam int T_HOLD = 40;
    localparam int T_WIN = 200;
    localparam int T_INT = 600;
    localparam int T_REC = 30;
    localparam int PER = 30;
    logic clk, reset_n;
    logic [NUM_TONES-1:0] tone_det;
    logic [NUM_POS-1:0][CHAR_W-1:0] code_plug;
    logic [NUM_CMDS-1:0] cmd_out;
    logic function_window, reject_latch, false_char, message_reset;
    logic fw_d1, fw_d2, fw_any;
    logic [31:0] lfsr;
    int failures, samples_checked, cyc, false_seen, n, t0, t9, k;
    int perm [21];
    // command tones, one based: second character shares lo, hi one higher
    int cmd_lo [5] = '{1, 2, 4, 3, 5};
    int cmd_hi [5] = '{2, 3, 5, 4, 6};

    stcd_decoder #(.NINTH_DELAY_LEN(T_NINTH), .HOLD_OFF_LEN(T_HOLD), .WINDOW_LEN(T_WIN),
        .INTERVAL_LEN(T_INT), .RECOVERY_LEN(T_REC)) u_stcd_decoder (.clk(clk), .reset_n(reset_n),
        .tone_det(tone_det), .code_plug(code_plug), .cmd_out(cmd_out), .function_window(function_window),
        .reject_latch(reject_latch), .false_char(false_char), .message_reset(message_reset));
    stcd_tone_src u_stcd_tone_src (.clk(clk), .tone_det(tone_det));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic int rnd(input int m);
        lfsr = lfsr_next(lfsr);
        rnd = int'(lfsr[15:0]) % m;
    endfunction : rnd

    // character number of a zero based tone pair, by counting pairs
    function automatic int chr(input int lo, input int hi);
        int c;
        c = 0;
        for (int a = 0; a < 7; a++)
            for (int b = a + 1; b < 7; b++)
            begin
                if (a == lo && b == hi) return c;
                c++;
            end
        return -1;
    endfunction : chr

    function automatic logic [6:0] char_mask(input int idx);
        for (int a = 0; a < 7; a++)
            for (int b = a + 1; b < 7; b++)
                if (chr(a, b) == idx) return (7'h01 << a) | (7'h01 << b);
        return 7'h00;
    endfunction : char_mask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (exp !== got)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_range

    task automatic summarize;
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // random plug with the command's first character at position nine, second at eight
    task automatic build_plug(input int c);
        int f, s, j, tmp;
        f = chr(cmd_lo[c] - 1, cmd_hi[c] - 1);
        s = chr(cmd_lo[c] - 1, cmd_hi[c]);
        for (int i = 0; i < 21; i++) perm[i] = i;
        for (int i = 20; i > 0; i--)
        begin
            j = rnd(i + 1);
            tmp = perm[i];
            perm[i] = perm[j];
            perm[j] = tmp;
        end
        for (int i = 0; i < 21; i++) if (perm[i] == f) begin perm[i] = perm[8]; perm[8] = f; end
        for (int i = 0; i < 21; i++) if (perm[i] == s) begin perm[i] = perm[7]; perm[7] = s; end
        for (int i = 0; i < 9; i++) code_plug[i] = perm[i][4:0];
    endtask : build_plug

    // plug is strapped before release; its sync, held at zero in reset, settles two cycles after release
    task automatic do_reset;
        reset_n = 1'b0;
        repeat (5) @(posedge clk);
        #2;
        reset_n = 1'b1;
        false_seen = 0;
        chk_val("outputs after reset", 0, {cmd_out, function_window, reject_latch, false_char});
    endtask : do_reset

    task automatic send_pos(input int p, input int hold);
        u_stcd_tone_src.send(char_mask(perm[p]), hold, PER - hold);
    endtask : send_pos

    // 0: message reset pulse, 1: window open, 2: window closed
    task automatic wait_for(input int which, output int m);
        m = 0;
        do
        begin
            @(posedge clk);
            #2;
            m++;
        end
        while (m < 2000 && !((which == 0 && message_reset === 1'b1) || (which == 1 && function_window === 1'b1)
            || (which == 2 && function_window === 1'b0)));
        chk_range("wait bound", 0, 1999, m);
    endtask : wait_for

    // ****************************************************************
    // clock, monitor, watchdog
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // relay outputs may only lag the window by the two register stages
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        fw_d1 <= function_window;
        fw_d2 <= fw_d1;
        fw_any <= fw_any | function_window;
        if (false_char === 1'b1) false_seen <= false_seen + 1;
        if (function_window === 1'b0 && fw_d1 === 1'b0 && fw_d2 === 1'b0) chk_val("cmd idle", 0, cmd_out);
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        summarize();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial
    begin
        lfsr = 32'h96B24318;
        reset_n = 1'b0;
        code_plug = '0;
        cyc = 0;
        failures = 0;
        samples_checked = 0;
        // friendly message for every command, ninth char equal to tenth
        for (int c = 0; c < NUM_CMDS; c++)
        begin
            build_plug(c);
            do_reset();
            t0 = cyc;
            // position two goes out twice: a repeat must not count as false
            for (int p = 0; p < 10; p++)
            begin
                t9 = cyc;
                send_pos((p < 2) ? p : p - 1, 12 + rnd(9));
            end
            wait_for(1, n);
            chk_range("window delay", T_NINTH + T_HOLD, T_NINTH + T_HOLD + 10, cyc - t9);
            t9 = cyc;
            send_pos(8, 20);
            chk_val("cmd after tenth", 0, cmd_out);
            u_stcd_tone_src.send(char_mask(perm[7]), 3 * PER - 10, 10);
            chk_val("cmd after eleventh", 32'h1 << c, cmd_out);
            wait_for(2, n);
            chk_range("window length", T_WIN - 1, T_WIN + 1, cyc - t9);
            repeat (2) @(posedge clk);
            #2;
            chk_val("cmd after close", 0, cmd_out);
            wait_for(0, n);
            chk_range("interval", T_INT, T_INT + 12, cyc - t0);
            chk_val("false count friendly", 0, false_seen);
            repeat (T_REC + 5) @(posedge clk);
        end
        // out of order, a char inside the clear, then a full address
        build_plug(rnd(5));
        do_reset();
        fw_any = 1'b0;
        send_pos(0, 15);
        u_stcd_tone_src.send(char_mask(perm[2]), 4, 2);
        u_stcd_tone_src.send(char_mask(perm[1]), 10, 20);
        chk_val("false on skip", 1, false_seen);
        chk_val("reject set", 1, reject_latch);
        send_pos(1, 15);
        chk_val("false after clear", 2, false_seen);
        for (int p = 0; p < 9; p++) send_pos(p, 15);
        wait_for(0, n);
        chk_val("window blocked", 0, fw_any);
        chk_val("reject cleared", 0, reject_latch);
        // every unused character starts the interval and is refused
        for (int u = 9; u < 21; u++)
        begin
            do_reset();
            t0 = cyc;
            u_stcd_tone_src.send(char_mask(perm[u]), 12 + rnd(9), 10);
            chk_val("unused false", 1, false_seen);
            wait_for(0, n);
            chk_range("unused interval", T_INT, T_INT + 12, cyc - t0);
        end
        // position two first after power-up, then three tones at once
        do_reset();
        send_pos(1, 15);
        chk_val("pos2 first", 1, false_seen);
        do_reset();
        send_pos(0, 15);
        k = rnd(7);
        while ((char_mask(perm[1]) & (7'h01 << k)) != 7'h00) k = rnd(7);
        u_stcd_tone_src.send(char_mask(perm[1]) | (7'h01 << k), 15, 15);
        chk_val("three tones", 1, reject_latch);
        summarize();
    end
endmodule : tb_secure_tone_command_decoder
